// File: mrs_far_side.sv
// Far-side model: reset switch, supply monitor and watchdog expiry strobe.
// Assumes the bench commands it just after falling clock edges.
`timescale 1ns/1ps
`default_nettype none
module mrs_far_side (
	input  wire logic i_press,
	input  wire logic i_dip,
	input  wire logic i_bite,
	output logic      o_pin_n,
	output logic      o_supply_low,
	output logic      o_expiry
);
	assign o_pin_n = !i_press;
	assign o_supply_low = i_dip;
	assign o_expiry = i_bite;
endmodule
`default_nettype wire

// File: mrs_pkg.sv
// Constants, reset values and state encodings for the reset sequencer.
// Assumes a single 250 MHz system clock; no other file is required.
package mrs_pkg;

	// --------------------------------------------------------------
	// Reset values
	// --------------------------------------------------------------
	localparam logic [7:0] MRS_PCL_RST      = 8'h00;
	localparam logic [7:0] MRS_TMRC_RST     = 8'h08;
	localparam logic [7:0] MRS_PORT_RST     = 8'hFF;
	localparam logic [7:0] MRS_CONV_RST     = 8'h40;
	localparam logic [6:0] MRS_INTA_RST     = 7'h00;
	localparam logic [1:0] MRS_INTB_RST     = 2'h0;
	localparam logic [2:0] MRS_SP_TOP       = 3'h0;

	// --------------------------------------------------------------
	// Timing
	// --------------------------------------------------------------
	localparam int MRS_CLK_NS               = 4;
	localparam int MRS_STARTUP_NS           = 4096;
	localparam int MRS_STARTUP_CYC          = MRS_STARTUP_NS / MRS_CLK_NS;
	localparam int MRS_QUALIFY_NS           = 1000;
	localparam int MRS_QUALIFY_CYC          = (MRS_QUALIFY_NS + MRS_CLK_NS - 1)
		/ MRS_CLK_NS;
	localparam int MRS_CNT_W                = 16;

	// --------------------------------------------------------------
	// Cause codes and states
	// --------------------------------------------------------------
	typedef enum logic [2:0] {
		MRS_CAUSE_NONE    = 3'h0,
		MRS_CAUSE_POWERON = 3'h1,
		MRS_CAUSE_PIN     = 3'h2,
		MRS_CAUSE_LOWSUP  = 3'h3,
		MRS_CAUSE_WDT_RUN = 3'h4,
		MRS_CAUSE_WDT_PD  = 3'h5
	} mrs_cause_type;

	typedef enum logic [2:0] {
		MRS_ST_HOLD  = 3'b001,
		MRS_ST_DELAY = 3'b010,
		MRS_ST_RUN   = 3'b100
	} mrs_state_type;

endpackage

// File: mrs_reset_sequencer.sv
// Reset sequencer: merges the reset causes, times release and drives the
// reset values of the other units. Pins and the supply monitor are async
// and are synchronised here; the watchdog and core strobes share the clock.
`timescale 1ns/1ps
`default_nettype none

module mrs_reset_sequencer #(
	parameter int STARTUP_CYC = mrs_pkg::MRS_STARTUP_CYC,
	parameter int QUALIFY_CYC = mrs_pkg::MRS_QUALIFY_CYC
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_external_reset_pin_n,
	input  wire logic        i_supply_low,
	input  wire logic        i_low_supply_reset_en,
	input  wire logic [1:0]  i_low_supply_threshold_sel,
	input  wire logic        i_watchdog_expiry,
	input  wire logic        i_powerdown_mode,
	input  wire logic        i_halt_exec,
	input  wire logic        i_wdt_clear_exec,
	output logic             o_core_rst,
	output logic             o_pc_sp_clear,
	output logic [2:0]       o_reset_cause,
	output logic [1:0]       o_low_supply_threshold,
	output logic             o_watchdog_expiry_flag,
	output logic             o_powerdown_flag,
	output logic             o_watchdog_counter_clear,
	output logic             o_timer_prescaler_clear,
	output logic [7:0]       o_program_counter_low,
	output logic [2:0]       o_stack_pointer,
	output logic [6:0]       o_interrupt_control_a,
	output logic [1:0]       o_interrupt_control_b,
	output logic [7:0]       o_timer_a_control,
	output logic [7:0]       o_timer_b_control,
	output logic [7:0]       o_port_data,
	output logic [7:0]       o_port_a_direction,
	output logic [7:0]       o_converter_control,
	output logic             o_load_full_reset
);

	// --------------------------------------------------------------
	// Synchronisers
	// --------------------------------------------------------------
	logic [1:0] pin_sync_reg;
	logic [1:0] low_sync_reg;
	logic       pin_low;
	logic       low_seen;

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pin_sync_reg <= 2'h0;
			low_sync_reg <= 2'h0;
		end else begin
			pin_sync_reg <= {pin_sync_reg[0], i_external_reset_pin_n};
			low_sync_reg <= {low_sync_reg[0], i_supply_low};
		end
	end

	assign pin_low  = ~pin_sync_reg[1];
	assign low_seen = low_sync_reg[1];

	// --------------------------------------------------------------
	// Threshold capture
	// --------------------------------------------------------------
	logic [1:0] thr_reg;
	logic [1:0] thr_next;
	logic       por_seen_reg;
	logic       por_seen_next;

	always_comb begin
		thr_next      = thr_reg;
		por_seen_next = 1'b1;
		if (!por_seen_reg) begin
			thr_next = i_low_supply_threshold_sel;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			thr_reg      <= 2'h0;
			por_seen_reg <= 1'b0;
		end else begin
			thr_reg      <= thr_next;
			por_seen_reg <= por_seen_next;
		end
	end

	assign o_low_supply_threshold = thr_reg;

	// --------------------------------------------------------------
	// Low-supply qualification
	// --------------------------------------------------------------
	logic [mrs_pkg::MRS_CNT_W-1:0] qual_reg;
	logic [mrs_pkg::MRS_CNT_W-1:0] qual_next;
	logic                          low_fire;

	always_comb begin
		qual_next = '0;
		low_fire  = 1'b0;
		if (low_seen && i_low_supply_reset_en) begin
			if (qual_reg >= mrs_pkg::MRS_CNT_W'(QUALIFY_CYC)) begin
				qual_next = qual_reg;
				low_fire  = 1'b1;
			end else begin
				qual_next = qual_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			qual_reg <= '0;
		end else begin
			qual_reg <= qual_next;
		end
	end

	// --------------------------------------------------------------
	// Sequencer
	// --------------------------------------------------------------
	mrs_pkg::mrs_state_type        st_reg;
	mrs_pkg::mrs_state_type        st_next;
	logic [mrs_pkg::MRS_CNT_W-1:0] dly_reg;
	logic [mrs_pkg::MRS_CNT_W-1:0] dly_next;
	logic [2:0]                    cause_reg;
	logic [2:0]                    cause_next;
	logic                          to_reg;
	logic                          to_next;
	logic                          pd_reg;
	logic                          pd_next;
	logic                          pcsp_reg;
	logic                          pcsp_next;
	logic                          full_reg;
	logic                          full_next;
	logic                          wdt_run;
	logic                          wdt_pd;

	assign wdt_run = i_watchdog_expiry && !i_powerdown_mode;
	assign wdt_pd  = i_watchdog_expiry && i_powerdown_mode;

	always_comb begin
		st_next    = st_reg;
		dly_next   = dly_reg;
		cause_next = cause_reg;
		to_next    = to_reg;
		pd_next    = pd_reg;
		pcsp_next  = 1'b0;
		full_next  = 1'b0;
		if (i_halt_exec) begin
			pd_next = 1'b1;
			to_next = 1'b0;
		end else if (i_wdt_clear_exec) begin
			pd_next = 1'b0;
		end
		unique case (st_reg)
			mrs_pkg::MRS_ST_HOLD: begin
				full_next = 1'b1;
				dly_next  = '0;
				if (!pin_low && !low_fire) begin
					st_next = mrs_pkg::MRS_ST_DELAY;
				end
			end
			mrs_pkg::MRS_ST_DELAY: begin
				if (pin_low || low_fire) begin
					st_next = mrs_pkg::MRS_ST_HOLD;
				end else if (dly_reg >= mrs_pkg::MRS_CNT_W'(STARTUP_CYC)) begin
					st_next = mrs_pkg::MRS_ST_RUN;
				end else begin
					dly_next = dly_reg + 1'b1;
				end
			end
			mrs_pkg::MRS_ST_RUN: begin
				if (pin_low) begin
					st_next    = mrs_pkg::MRS_ST_HOLD;
					cause_next = mrs_pkg::MRS_CAUSE_PIN;
				end else if (low_fire) begin
					st_next    = mrs_pkg::MRS_ST_HOLD;
					cause_next = mrs_pkg::MRS_CAUSE_LOWSUP;
				end else if (wdt_run) begin
					st_next    = mrs_pkg::MRS_ST_HOLD;
					cause_next = mrs_pkg::MRS_CAUSE_WDT_RUN;
					to_next    = 1'b1;
				end else if (wdt_pd) begin
					cause_next = mrs_pkg::MRS_CAUSE_WDT_PD;
					to_next    = 1'b1;
					pd_next    = 1'b1;
					pcsp_next  = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_reg    <= mrs_pkg::MRS_ST_HOLD;
			dly_reg   <= '0;
			cause_reg <= mrs_pkg::MRS_CAUSE_POWERON;
			to_reg    <= 1'b0;
			pd_reg    <= 1'b0;
			pcsp_reg  <= 1'b0;
			full_reg  <= 1'b1;
		end else begin
			st_reg    <= st_next;
			dly_reg   <= dly_next;
			cause_reg <= cause_next;
			to_reg    <= to_next;
			pd_reg    <= pd_next;
			pcsp_reg  <= pcsp_next;
			full_reg  <= full_next;
		end
	end

	assign o_core_rst = i_sys_rst || (st_reg != mrs_pkg::MRS_ST_RUN);

	// --------------------------------------------------------------
	// Reset values to the other units
	// --------------------------------------------------------------
	// The values are constant; full_reg tells units when to load them,
	// so a halted watchdog reset leaves them untouched.
	assign o_load_full_reset        = full_reg;
	assign o_pc_sp_clear            = pcsp_reg;
	assign o_reset_cause            = cause_reg;
	assign o_watchdog_expiry_flag   = to_reg;
	assign o_powerdown_flag         = pd_reg;
	assign o_watchdog_counter_clear = full_reg || pcsp_reg;
	assign o_timer_prescaler_clear  = full_reg;
	assign o_program_counter_low    = mrs_pkg::MRS_PCL_RST;
	assign o_stack_pointer          = mrs_pkg::MRS_SP_TOP;
	assign o_interrupt_control_a    = mrs_pkg::MRS_INTA_RST;
	assign o_interrupt_control_b    = mrs_pkg::MRS_INTB_RST;
	assign o_timer_a_control        = mrs_pkg::MRS_TMRC_RST;
	assign o_timer_b_control        = mrs_pkg::MRS_TMRC_RST;
	assign o_port_data              = mrs_pkg::MRS_PORT_RST;
	assign o_port_a_direction       = mrs_pkg::MRS_PORT_RST;
	assign o_converter_control      = mrs_pkg::MRS_CONV_RST;

endmodule

`default_nettype wire

// File: mrs_reset_sequencer_chk.sv
// Port checker for the reset sequencer.
// Assumes it is bound to every instance of the sequencer.
`timescale 1ns/1ps
`default_nettype none
module mrs_reset_sequencer_chk #(
	parameter int STARTUP_CYC = 4
) (
	input wire logic       i_ref_clk,
	input wire logic       i_sys_rst,
	input wire logic       i_external_reset_pin_n,
	input wire logic       i_supply_low,
	input wire logic       i_watchdog_expiry,
	input wire logic       i_powerdown_mode,
	input wire logic       o_core_rst,
	input wire logic       o_pc_sp_clear,
	input wire logic [2:0] o_reset_cause,
	input wire logic       o_watchdog_expiry_flag,
	input wire logic       o_powerdown_flag,
	input wire logic       o_watchdog_counter_clear,
	input wire logic       o_timer_prescaler_clear,
	input wire logic       o_load_full_reset
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_sys_rst);
	// Counts reset-high cycles; no cap, as a sim run is short.
	int hold_cnt;
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			hold_cnt <= 0;
		end else begin
			hold_cnt <= o_core_rst ? hold_cnt + 1 : 0;
		end
	end
	sequence s_quiet;
		(i_external_reset_pin_n && !i_supply_low) [*3];
	endsequence
	property p_hold;
		$fell(o_core_rst) |-> hold_cnt > STARTUP_CYC;
	endproperty
	a_hold: assert property (p_hold) else $error("early release");
	property p_wrun;
		s_quiet ##0 (!o_core_rst && i_watchdog_expiry && !i_powerdown_mode)
		|=> o_core_rst && o_watchdog_expiry_flag && o_reset_cause == 3'h4;
	endproperty
	a_wrun: assert property (p_wrun) else $error("run expiry");
	property p_wpd;
		s_quiet ##0 (!o_core_rst && i_watchdog_expiry && i_powerdown_mode)
		|=> o_pc_sp_clear && !o_core_rst && o_reset_cause == 3'h5
		&& o_watchdog_expiry_flag && o_powerdown_flag;
	endproperty
	a_wpd: assert property (p_wpd) else $error("halted expiry");
	property p_pin;
		!i_external_reset_pin_n [*3] |=> o_core_rst && o_reset_cause == 3'h2;
	endproperty
	a_pin: assert property (p_pin) else $error("pin reset");
	property p_refuse;
		o_core_rst && i_watchdog_expiry |=> !o_pc_sp_clear;
	endproperty
	a_refuse: assert property (p_refuse) else $error("expiry in reset");
	property p_pulse;
		o_pc_sp_clear && !i_watchdog_expiry |=> !o_pc_sp_clear;
	endproperty
	a_pulse: assert property (p_pulse) else $error("clear too long");
	property p_keep;
		o_pc_sp_clear |-> !o_load_full_reset && !o_core_rst;
	endproperty
	a_keep: assert property (p_keep) else $error("state lost");
	property p_clr;
		o_watchdog_counter_clear == (o_load_full_reset || o_pc_sp_clear)
		&& o_timer_prescaler_clear == o_load_full_reset;
	endproperty
	a_clr: assert property (p_clr) else $error("clear strobes");
	c_wpd: cover property (o_pc_sp_clear);
	c_low: cover property (o_core_rst && o_reset_cause == 3'h3);
	c_rel: cover property ($fell(o_core_rst));
endmodule
bind mrs_reset_sequencer mrs_reset_sequencer_chk #(
	.STARTUP_CYC(STARTUP_CYC)) i_mrs_reset_sequencer_chk (.*);
`default_nettype wire

// File: test_mrs_reset_sequencer.sv
// Self-checking bench for the reset sequencer and its far side.
// Assumes short start-up and qualify counts; inputs move on falling edges.
`timescale 1ns/1ps
`default_nettype none
module test_mrs_reset_sequencer;
	localparam int SC = 4;
	logic       i_ref_clk = 0;
	logic       i_sys_rst = 1;
	logic       i_external_reset_pin_n, i_supply_low, i_watchdog_expiry;
	logic       i_low_supply_reset_en, i_powerdown_mode, i_halt_exec;
	logic       i_wdt_clear_exec, press, dip, bite, p;
	logic [1:0] i_low_supply_threshold_sel, o_low_supply_threshold, fl;
	logic [1:0] o_interrupt_control_b;
	logic       o_core_rst, o_pc_sp_clear, o_watchdog_expiry_flag;
	logic       o_powerdown_flag, o_watchdog_counter_clear;
	logic       o_timer_prescaler_clear, o_load_full_reset;
	logic [2:0] o_reset_cause, o_stack_pointer;
	logic [6:0] o_interrupt_control_a, ex;
	logic [7:0] o_program_counter_low, o_timer_a_control, o_timer_b_control;
	logic [7:0] o_port_data, o_port_a_direction, o_converter_control;
	int         err_count = 0;
	int         compares = 0;
	int         cyc = 0;
	int         n, k;
	wire [1:0]  fs = {o_watchdog_expiry_flag, o_powerdown_flag};
	wire [63:0] rv = {o_load_full_reset, o_watchdog_counter_clear,
		o_timer_prescaler_clear, o_core_rst, o_port_data, o_port_a_direction,
		o_timer_a_control, o_timer_b_control, o_converter_control,
		o_program_counter_low, o_interrupt_control_a, o_interrupt_control_b,
		o_stack_pointer};
	always #2 i_ref_clk = ~i_ref_clk;
	mrs_reset_sequencer #(.STARTUP_CYC(SC), .QUALIFY_CYC(3))
		i_mrs_reset_sequencer (.*);
	mrs_far_side i_mrs_far_side (
		.i_press      (press),
		.i_dip        (dip),
		.i_bite       (bite),
		.o_pin_n      (i_external_reset_pin_n),
		.o_supply_low (i_supply_low),
		.o_expiry     (i_watchdog_expiry)
	);
	task automatic chk(input string what, input logic [63:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// A hang is cut short well past the fewer than 200 cycles needed.
	always @(posedge i_ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			report_and_stop();
		end
	end
	task automatic wait_run(output int m);
		m = 0;
		while (o_core_rst !== 1'b0 && m < 300) begin
			@(negedge i_ref_clk);
			m++;
		end
		chk("run", m < 300, 1'b1);
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		@(negedge i_ref_clk);
		s = 0;
	endtask
	function automatic logic [1:0] exp_fl(input logic [2:0] c, logic [1:0] q);
		case (c)
			3'h1: return 2'h0;
			3'h4: return {1'b1, q[0]};
			3'h5: return 2'h3;
			default: return q;
		endcase
	endfunction
	task automatic low(input int len, input logic en, input logic e);
		i_low_supply_reset_en = en;
		dip = 1;
		repeat (len) @(negedge i_ref_clk);
		dip = 0;
		repeat (2) @(negedge i_ref_clk);
		chk("low", {o_core_rst, o_reset_cause, fs}, {e, e ? 3'h3 : 3'h2, fl});
		wait_run(n);
		repeat (4) @(negedge i_ref_clk);
	endtask
	initial begin
		void'($urandom(32'hECF15925));
		{press, dip, bite, i_powerdown_mode, i_halt_exec} = '0;
		{i_wdt_clear_exec, i_low_supply_reset_en} = 2'h1;
		i_low_supply_threshold_sel = 2'($urandom);
		repeat (12) @(negedge i_ref_clk);
		chk("rstval", rv, 64'hFFFFF08084000000);
		i_sys_rst = 0;
		wait_run(n);
		chk("podelay", n > SC, 1'b1);
		chk("poweron", {o_reset_cause, fs}, 5'h04);
		chk("thresh", o_low_supply_threshold, i_low_supply_threshold_sel);
		fl = 2'h0;
		$display("power-on test done");
		repeat (8) begin
			p = 1'($urandom);
			if ($urandom % 2) begin
				pulse(i_halt_exec);
				fl = 2'h1;
			end
			i_powerdown_mode = p;
			pulse(bite);
			fl = exp_fl(p ? 3'h5 : 3'h4, fl);
			ex = {p, !p, p ? 3'h5 : 3'h4, fl};
			chk("wdt", {o_pc_sp_clear, o_core_rst, o_reset_cause, fs}, ex);
			if (!p) begin
				i_powerdown_mode = 1;
				pulse(bite);
				chk("refuse", o_pc_sp_clear, 1'b0);
				wait_run(n);
			end
			i_powerdown_mode = 0;
		end
		$display("watchdog test done");
		k = 3 + $urandom % 8;
		press = 1;
		repeat (k) @(negedge i_ref_clk);
		chk("pin", {o_core_rst, o_reset_cause, fs}, {1'b1, 3'h2, fl});
		press = 0;
		wait_run(n);
		chk("pindelay", n > SC + 2, 1'b1);
		$display("pin test done");
		low(2, 1'b1, 1'b0);
		low(12, 1'b0, 1'b0);
		low(12, 1'b1, 1'b1);
		$display("low supply test done");
		pulse(i_halt_exec);
		chk("halt", fs, 2'h1);
		pulse(i_wdt_clear_exec);
		chk("wclear", o_powerdown_flag, 1'b0);
		pulse(i_halt_exec);
		i_sys_rst = 1;
		@(negedge i_ref_clk);
		chk("rstval2", rv, 64'hFFFFF08084000000);
		i_sys_rst = 0;
		wait_run(n);
		chk("poweron2", {o_reset_cause, fs}, 5'h04);
		$display("flag test done");
		report_and_stop();
	end
endmodule
`default_nettype wire
